// ---- bench/io_stage_output_control_tb.sv ----
// self-checking bench for the io stage control block
`timescale 1ns/100ps
`include "iosc_regs.svh"
module io_stage_output_control_tb;
    import iosc_pkg::*;
    localparam logic [4:0] IDENT = 5'h0B; // arbitrary value
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic OUTPUT_FORCE_OFF_N = 1'b1;
    logic FLASH_FREQUENCY_PIN = 1'b0;
    logic EXTERNAL_RESET_N = 1'b1;
    logic OVER_UPPER_THRESHOLD = 1'b0;
    logic BELOW_RECOVERY_THRESHOLD = 1'b1;
    logic LOGIC_SUPPLY_LOW = 1'b0;
    logic GROUND_BOND_BREAK = 1'b0;
    logic [3:0] STAGE_SUPPLY_LOW = 4'h0;
    logic ADC_DONE = 1'b0;
    logic [15:0] IO_LEVEL_IN;
    logic [15:0] OVERCURRENT_IN;
    logic [15:0] IO_DRIVE_EN;
    iosc_bias_t [3:0] BIAS;
    logic CLOCK_SOURCE_INTERNAL;
    logic [15:0] contact = 16'h0;
    logic [15:0] shorted = 16'h0;
    logic pin_run = 1'b0;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int bad = 0;
    int tg;
    logic [5:0] rw_idx [10] = '{6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h1A};

    iosc_top #(.IDENTITY(IDENT), .FLASH_TICK_CYCLES(4)) i_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .OUTPUT_FORCE_OFF_N(OUTPUT_FORCE_OFF_N), .FLASH_FREQUENCY_PIN(FLASH_FREQUENCY_PIN),
        .EXTERNAL_RESET_N(EXTERNAL_RESET_N), .OVER_UPPER_THRESHOLD(OVER_UPPER_THRESHOLD),
        .BELOW_RECOVERY_THRESHOLD(BELOW_RECOVERY_THRESHOLD), .LOGIC_SUPPLY_LOW(LOGIC_SUPPLY_LOW),
        .GROUND_BOND_BREAK(GROUND_BOND_BREAK), .STAGE_SUPPLY_LOW(STAGE_SUPPLY_LOW), .ADC_DONE(ADC_DONE),
        .IO_LEVEL_IN(IO_LEVEL_IN), .OVERCURRENT_IN(OVERCURRENT_IN), .IO_DRIVE_EN(IO_DRIVE_EN), .BIAS(BIAS),
        .CLOCK_SOURCE_INTERNAL(CLOCK_SOURCE_INTERNAL));

    iosc_load_model i_load (.drive_en(IO_DRIVE_EN), .contact_closed(contact), .load_shorted(shorted),
        .level(IO_LEVEL_IN), .overcurrent(OVERCURRENT_IN));

    always #10 SYS_CLK = ~SYS_CLK;

    always @(posedge SYS_CLK)
    begin
        if (pin_run)
            FLASH_FREQUENCY_PIN <= ~FLASH_FREQUENCY_PIN;
    end

    always @(posedge SYS_CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checked %0d values, %0d wrong", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask : cyc

    // one avalon transfer, called just after a rising edge
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] q);
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        AVS_WRITEDATA <= {24'h0, wd};
        // hold the request until waitrequest is sampled low at a rising edge
        do
            @(posedge SYS_CLK);
        while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA[7:0];
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge SYS_CLK);
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        check(what, {8'h0, q}, {8'h0, exp});
    endtask : rchk

    // watches stage 1 for phase changes and the stage 1..4 pattern
    task automatic watch(input int n, output int t);
        logic p;
        t = 0;
        p = IO_DRIVE_EN[0];
        repeat (n)
        begin
            @(negedge SYS_CLK);
            if (IO_DRIVE_EN[0] !== p)
                t++;
            if (IO_DRIVE_EN[3:0] !== 4'h0 && IO_DRIVE_EN[3:0] !== 4'h5)
                bad++;
            p = IO_DRIVE_EN[0];
        end
        @(posedge SYS_CLK);
    endtask : watch

    initial
    begin
        cyc(3);
        RESET_N <= 1'b1;
        cyc(1);
        foreach (rw_idx[i]) rchk("reset value", rw_idx[i], 8'h00);
        rchk("identity", 6'h1D, {3'b000, IDENT});
        rchk("unmapped", 6'h30, 8'h00);
        foreach (rw_idx[i]) wr(rw_idx[i], {rw_idx[i][3:0], ~rw_idx[i][3:0]});
        foreach (rw_idx[i]) rchk("readback", rw_idx[i], {rw_idx[i][3:0], ~rw_idx[i][3:0]});
        wr(6'h19, 8'h02);
        rchk("clock cfg", 6'h19, 8'h02);
        check("osc select", CLOCK_SOURCE_INTERNAL, 16'h1);
        wr(6'h1D, 8'hFF);
        rchk("read only", 6'h1D, {3'b000, IDENT});
        EXTERNAL_RESET_N <= 1'b0;
        cyc(4);
        rchk("reset pin flag", 6'h1D, {3'b001, IDENT});
        foreach (rw_idx[i]) rchk("ext reset", rw_idx[i], 8'h00);
        rchk("ext reset clk", 6'h19, 8'h00);
        EXTERNAL_RESET_N <= 1'b1;
        AVS_BYTEENABLE <= 4'hE;
        cyc(4);
        wr(6'h0C, 8'hFF);
        AVS_BYTEENABLE <= 4'hF;
        rchk("byte enable", 6'h0C, 8'h00);
        GROUND_BOND_BREAK <= 1'b1;
        STAGE_SUPPLY_LOW <= 4'b0100;
        ADC_DONE <= 1'b1;
        LOGIC_SUPPLY_LOW <= 1'b1;
        cyc(4);
        rchk("fault flags", 6'h1D, {3'b110, IDENT});
        rchk("events set", 6'h05, 8'h14);
        GROUND_BOND_BREAK <= 1'b0;
        STAGE_SUPPLY_LOW <= 4'h0;
        ADC_DONE <= 1'b0;
        LOGIC_SUPPLY_LOW <= 1'b0;
        cyc(4);
        rchk("events clear", 6'h05, 8'h00);
        // all groups output, group 0 with pull-up bias level 1
        wr(6'h16, 8'h1B);
        wr(6'h17, 8'h11);
        wr(6'h0C, 8'hA5);
        wr(6'h0D, 8'h3C);
        cyc(2);
        check("drive", IO_DRIVE_EN, 16'h3CA5);
        check("bias", {4'h0, BIAS}, 16'h0005);
        wr(6'h17, 8'h10);
        cyc(2);
        check("group input", IO_DRIVE_EN, 16'h30A5);
        wr(6'h17, 8'h11);
        OUTPUT_FORCE_OFF_N <= 1'b0;
        cyc(5);
        check("force off", IO_DRIVE_EN, 16'h0000);
        OUTPUT_FORCE_OFF_N <= 1'b1;
        cyc(5);
        check("force on", IO_DRIVE_EN, 16'h3CA5);
        shorted <= 16'h0001;
        cyc(4);
        rchk("overcurrent", 6'h02, 8'h01);
        shorted <= 16'h0000;
        wr(6'h0E, 8'h0F);
        watch(40, tg);
        check("fast flash", tg >= 9, 16'h1);
        wr(6'h18, 8'h01);
        watch(40, tg);
        check("slow flash", tg >= 4 && tg <= 5, 16'h1);
        wr(6'h19, 8'h01);
        cyc(4);
        check("osc off", CLOCK_SOURCE_INTERNAL, 16'h0);
        watch(20, tg);
        check("pin idle", tg, 16'h0);
        pin_run <= 1'b1;
        watch(40, tg);
        pin_run <= 1'b0;
        check("pin flash", tg >= 4, 16'h1);
        check("flash pattern", bad, 16'h0);
        check("steady stages", IO_DRIVE_EN[15:4], 16'h03CA);
        OVER_UPPER_THRESHOLD <= 1'b1;
        BELOW_RECOVERY_THRESHOLD <= 1'b0;
        cyc(5);
        check("hot drive", IO_DRIVE_EN, 16'h0000);
        check("hot bias", {13'h0, BIAS[0]}, 16'h0000);
        OVER_UPPER_THRESHOLD <= 1'b0;
        cyc(5);
        rchk("hot oe a", 6'h0C, 8'h00);
        rchk("hot oe b", 6'h0D, 8'h00);
        rchk("hot flash a", 6'h0E, 8'h00);
        rchk("hot flash b", 6'h0F, 8'h00);
        check("warm bias", {13'h0, BIAS[0]}, 16'h0000);
        BELOW_RECOVERY_THRESHOLD <= 1'b1;
        cyc(5);
        check("cool bias", {13'h0, BIAS[0]}, 16'h0005);
        wr(6'h14, 8'h0F);
        contact <= 16'h0011;
        cyc(6);
        rchk("filter early", 6'h00, 8'h10);
        cyc(30);
        rchk("filter late", 6'h00, 8'h11);
        finish_test();
    end
endmodule : io_stage_output_control_tb

// ---- bench/iosc_load_model.sv ----
// load and switch-contact model standing on the io stage pins
`timescale 1ns/100ps
module iosc_load_model (
    input wire logic [15:0] drive_en,
    input wire logic [15:0] contact_closed,
    input wire logic [15:0] load_shorted,
    output logic [15:0] level,
    output logic [15:0] overcurrent
);
    // a driven stage reads high, an input stage reads its contact
    assign level = drive_en | contact_closed;
    // a shorted load draws overcurrent only while it is driven
    assign overcurrent = drive_en & load_shorted;
endmodule : iosc_load_model

// ---- common/iosc_pkg.sv ----
// types shared by the io stage control block
package iosc_pkg;
    typedef enum logic {IOSC_IDLE, IOSC_ACK} iosc_bus_state_t;
    typedef struct packed {
        logic pull_up;
        logic [1:0] level;
    } iosc_bias_t;
endpackage : iosc_pkg

// ---- common/iosc_regs.svh ----
// register indexes, field positions, reset values and timing for the io stage control block
`ifndef IOSC_REGS_SVH
`define IOSC_REGS_SVH
`define IOSC_IDX_IN_A 6'h00
`define IOSC_IDX_IN_B 6'h01
`define IOSC_IDX_OC_A 6'h02
`define IOSC_IDX_OC_B 6'h03
`define IOSC_IDX_EVENT 6'h05
`define IOSC_IDX_OE_A 6'h0C
`define IOSC_IDX_OE_B 6'h0D
`define IOSC_IDX_FL_A 6'h0E
`define IOSC_IDX_FL_B 6'h0F
`define IOSC_IDX_FILT_LO 6'h14
`define IOSC_IDX_FILT_HI 6'h15
`define IOSC_IDX_DIR_LO 6'h16
`define IOSC_IDX_DIR_HI 6'h17
`define IOSC_IDX_FREQ 6'h18
`define IOSC_IDX_CLK 6'h19
`define IOSC_IDX_OCF 6'h1A
`define IOSC_IDX_FAULT 6'h1D
`define IOSC_EVT_ADC_BIT 2
`define IOSC_EVT_LSL_BIT 4
`define IOSC_FLT_GND_BIT 7
`define IOSC_FLT_VB_BIT 6
`define IOSC_FLT_RES_BIT 5
`define IOSC_CLK_FLASH_PIN_BIT 0
`define IOSC_CLK_INT_OSC_BIT 1
`define IOSC_DIR_OUT_BIT 0
`define IOSC_BIAS_LVL_LSB 1
`define IOSC_BIAS_UP_BIT 3
`define IOSC_RST_OE 8'h00
`define IOSC_RST_FLASH 8'h00
`define IOSC_RST_FILT 8'h00
`define IOSC_RST_DIR 8'h00
`define IOSC_RST_FREQ 8'h00
`define IOSC_RST_CLK 8'h00
`define IOSC_RST_OCF 8'h00
`define IOSC_CLK_NS 20
`define IOSC_FLASH_TICK_NS 1000000
`endif

// ---- rtl/iosc_top.sv ----
// io stage control: output enables, flash, bias, filters and register file
// What this block does
// - event register shows conversion finished as 1
// - event register shows logic supply low as 1
// - fault register holds ground, supply, reset flags
// - fixed five-bit identity in fault register low bits
// - direction chosen per group of four stages
// - groups 0..3 map to stages 1..16
// - per-group debounce for levels and overcurrent
// - pull bias configurable in any mode, four levels
// - overtemperature turns bias off until recovery
// - output drives only with its enable bit
// - overtemperature clears both output enable registers
// - force-off pin low disables all outputs
// - per-output flash enable registers
// - flash timing from pin or system clock
// - clock source select bit drives clock mux
// - separate flash frequency for each group
// - flashing visible only on enabled outputs
// - overtemperature clears both flash enable registers
// - external reset low loads all defaults
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`include "iosc_regs.svh"
module iosc_top #(
    parameter logic [4:0] IDENTITY = 5'h0A, // arbitrary value
    parameter int unsigned FLASH_TICK_CYCLES = `IOSC_FLASH_TICK_NS / `IOSC_CLK_NS
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic OUTPUT_FORCE_OFF_N,
    input wire logic FLASH_FREQUENCY_PIN,
    input wire logic EXTERNAL_RESET_N,
    input wire logic OVER_UPPER_THRESHOLD,
    input wire logic BELOW_RECOVERY_THRESHOLD,
    input wire logic LOGIC_SUPPLY_LOW,
    input wire logic GROUND_BOND_BREAK,
    input wire logic [3:0] STAGE_SUPPLY_LOW,
    input wire logic ADC_DONE,
    input wire logic [15:0] IO_LEVEL_IN,
    input wire logic [15:0] OVERCURRENT_IN,
    output logic [15:0] IO_DRIVE_EN,
    output iosc_pkg::iosc_bias_t [3:0] BIAS,
    output logic CLOCK_SOURCE_INTERNAL
);
    import iosc_pkg::*;

    localparam int SW = 44;
    localparam logic [SW-1:0] SYNC_RST = {1'b0, 1'b0, 1'b1, 41'h0};

    function automatic logic [3:0] nib(input logic [15:0] v, input int n);
        nib = v[n*4 +: 4];
    endfunction : nib

    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic force_s;
    logic flpin_s;
    logic extrst_s;
    logic over_s;
    logic below_s;
    logic lsl_s;
    logic gnd_s;
    logic [3:0] vbl_s;
    logic adc_s;
    logic [31:0] raw_s;
    logic [31:0] filt;
    logic sw_rst;
    iosc_bus_state_t state_reg;
    logic [5:0] idx;
    logic wr;
    logic [15:0] oe_reg;
    logic [15:0] flash_reg;
    logic [15:0] filt_cfg_reg;
    logic [15:0] dir_cfg_reg;
    logic [7:0] freq_reg;
    logic [7:0] clk_reg;
    logic [7:0] ocf_reg;
    logic thermal_off_reg;
    logic [15:0] tick_cnt_reg;
    logic tick;
    logic flpin_d_reg;
    logic [3:0] phase_cnt_reg;
    logic [3:0] phase;
    logic [15:0] phase16;
    logic [15:0] dir16;
    logic [3:0] grp_cfg [4];
    logic [15:0] drive_next;
    logic [7:0] rd_next;

    // two-stage synchroniser for every pin
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
        end
        else
        begin
            sync1_reg <= {OUTPUT_FORCE_OFF_N, FLASH_FREQUENCY_PIN, EXTERNAL_RESET_N, OVER_UPPER_THRESHOLD,
                          BELOW_RECOVERY_THRESHOLD, LOGIC_SUPPLY_LOW, GROUND_BOND_BREAK, STAGE_SUPPLY_LOW,
                          ADC_DONE, OVERCURRENT_IN, IO_LEVEL_IN};
            sync2_reg <= sync1_reg;
        end
    end

    assign force_s = sync2_reg[43];
    assign flpin_s = sync2_reg[42];
    assign extrst_s = sync2_reg[41];
    assign over_s = sync2_reg[40];
    assign below_s = sync2_reg[39];
    assign lsl_s = sync2_reg[38];
    assign gnd_s = sync2_reg[37];
    assign vbl_s = sync2_reg[36:33];
    assign adc_s = sync2_reg[32];
    assign raw_s = sync2_reg[31:0];

    assign sw_rst = !RESET_N || !extrst_s;

    genvar g;
    generate
        for (g = 0; g < 32; g++)
        begin : g_filt
            logic [3:0] cnt_reg;
            logic val_reg;
            logic [3:0] thr;
            if (g < 16)
            begin : g_io
                assign thr = nib(filt_cfg_reg, g / 4);
            end
            else
            begin : g_oc
                assign thr = {ocf_reg[((g - 16) / 4) * 2 +: 2], 2'b00};
            end
            always_ff @(posedge SYS_CLK)
            begin
                if (sw_rst)
                begin
                    cnt_reg <= 4'h0;
                    val_reg <= 1'b0;
                end
                else if (raw_s[g] == val_reg)
                begin
                    cnt_reg <= 4'h0;
                end
                else if (cnt_reg >= thr)
                begin
                    cnt_reg <= 4'h0;
                    val_reg <= raw_s[g];
                end
                else
                begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
            assign filt[g] = val_reg;
        end
    endgenerate

    // bus handshake: one wait cycle per access
    assign idx = AVS_ADDRESS[7:2];
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (state_reg == IOSC_IDLE);
    assign wr = AVS_WRITE && (state_reg == IOSC_ACK) && AVS_BYTEENABLE[0];

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            state_reg <= IOSC_IDLE;
        end
        else
        begin
            case (state_reg)
                IOSC_IDLE: state_reg <= (AVS_READ || AVS_WRITE) ? IOSC_ACK : IOSC_IDLE;
                IOSC_ACK: state_reg <= IOSC_IDLE;
                default: state_reg <= IOSC_IDLE;
            endcase
        end
    end

    // thermal latch with hysteresis
    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst)
        begin
            thermal_off_reg <= 1'b0;
        end
        else if (over_s)
        begin
            thermal_off_reg <= 1'b1;
        end
        else if (below_s)
        begin
            thermal_off_reg <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst || over_s)
        begin
            oe_reg <= {`IOSC_RST_OE, `IOSC_RST_OE};
        end
        else if (wr && idx == `IOSC_IDX_OE_A)
        begin
            oe_reg[7:0] <= AVS_WRITEDATA[7:0];
        end
        else if (wr && idx == `IOSC_IDX_OE_B)
        begin
            oe_reg[15:8] <= AVS_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst || over_s)
        begin
            flash_reg <= {`IOSC_RST_FLASH, `IOSC_RST_FLASH};
        end
        else if (wr && idx == `IOSC_IDX_FL_A)
        begin
            flash_reg[7:0] <= AVS_WRITEDATA[7:0];
        end
        else if (wr && idx == `IOSC_IDX_FL_B)
        begin
            flash_reg[15:8] <= AVS_WRITEDATA[7:0];
        end
    end

    // configuration registers
    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst)
        begin
            filt_cfg_reg <= {`IOSC_RST_FILT, `IOSC_RST_FILT};
            dir_cfg_reg <= {`IOSC_RST_DIR, `IOSC_RST_DIR};
            freq_reg <= `IOSC_RST_FREQ;
            clk_reg <= `IOSC_RST_CLK;
            ocf_reg <= `IOSC_RST_OCF;
        end
        else if (wr)
        begin
            case (idx)
                `IOSC_IDX_FILT_LO: filt_cfg_reg[7:0] <= AVS_WRITEDATA[7:0];
                `IOSC_IDX_FILT_HI: filt_cfg_reg[15:8] <= AVS_WRITEDATA[7:0];
                `IOSC_IDX_DIR_LO: dir_cfg_reg[7:0] <= AVS_WRITEDATA[7:0];
                `IOSC_IDX_DIR_HI: dir_cfg_reg[15:8] <= AVS_WRITEDATA[7:0];
                `IOSC_IDX_FREQ: freq_reg <= AVS_WRITEDATA[7:0];
                `IOSC_IDX_CLK: clk_reg <= AVS_WRITEDATA[7:0];
                `IOSC_IDX_OCF: ocf_reg <= AVS_WRITEDATA[7:0];
                default: ocf_reg <= ocf_reg;
            endcase
        end
    end

    assign CLOCK_SOURCE_INTERNAL = clk_reg[`IOSC_CLK_INT_OSC_BIT];

    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst)
        begin
            tick_cnt_reg <= 16'h0000;
            flpin_d_reg <= 1'b0;
        end
        else
        begin
            tick_cnt_reg <= (tick_cnt_reg >= 16'(FLASH_TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt_reg + 16'h0001;
            flpin_d_reg <= flpin_s;
        end
    end

    assign tick = clk_reg[`IOSC_CLK_FLASH_PIN_BIT] ? (flpin_s && !flpin_d_reg)
                                                   : (tick_cnt_reg >= 16'(FLASH_TICK_CYCLES - 1));

    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst)
        begin
            phase_cnt_reg <= 4'h0;
        end
        else if (tick)
        begin
            phase_cnt_reg <= phase_cnt_reg + 4'h1;
        end
    end

    generate
        for (g = 0; g < 4; g++)
        begin : g_nib
            assign phase[g] = phase_cnt_reg[freq_reg[g*2 +: 2]];
            assign phase16[g*4 +: 4] = {4{phase[g]}};
            assign grp_cfg[g] = nib(dir_cfg_reg, g);
            assign dir16[g*4 +: 4] = {4{grp_cfg[g][`IOSC_DIR_OUT_BIT]}};
        end
    endgenerate

    assign drive_next = force_s ? (dir16 & oe_reg & (~flash_reg | phase16)) : 16'h0000;

    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst)
        begin
            IO_DRIVE_EN <= 16'h0000;
        end
        else
        begin
            IO_DRIVE_EN <= drive_next;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (sw_rst || thermal_off_reg)
        begin
            BIAS <= '0;
        end
        else
        begin
            for (int n = 0; n < 4; n++)
            begin
                BIAS[n].pull_up <= grp_cfg[n][`IOSC_BIAS_UP_BIT];
                BIAS[n].level <= grp_cfg[n][`IOSC_BIAS_LVL_LSB +: 2];
            end
        end
    end

    // read mux
    always_comb
    begin
        case (idx)
            `IOSC_IDX_IN_A: rd_next = filt[7:0];
            `IOSC_IDX_IN_B: rd_next = filt[15:8];
            `IOSC_IDX_OC_A: rd_next = filt[23:16];
            `IOSC_IDX_OC_B: rd_next = filt[31:24];
            `IOSC_IDX_EVENT: rd_next = {3'h0, lsl_s, 1'b0, adc_s, 2'h0};
            `IOSC_IDX_OE_A: rd_next = oe_reg[7:0];
            `IOSC_IDX_OE_B: rd_next = oe_reg[15:8];
            `IOSC_IDX_FL_A: rd_next = flash_reg[7:0];
            `IOSC_IDX_FL_B: rd_next = flash_reg[15:8];
            `IOSC_IDX_FILT_LO: rd_next = filt_cfg_reg[7:0];
            `IOSC_IDX_FILT_HI: rd_next = filt_cfg_reg[15:8];
            `IOSC_IDX_DIR_LO: rd_next = dir_cfg_reg[7:0];
            `IOSC_IDX_DIR_HI: rd_next = dir_cfg_reg[15:8];
            `IOSC_IDX_FREQ: rd_next = freq_reg;
            `IOSC_IDX_CLK: rd_next = clk_reg;
            `IOSC_IDX_OCF: rd_next = ocf_reg;
            `IOSC_IDX_FAULT: rd_next = {gnd_s, |vbl_s, !extrst_s, IDENTITY};
            default: rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESET_N)
        begin
            AVS_READDATA <= 32'h00000000;
        end
        else if (AVS_READ && state_reg == IOSC_IDLE)
        begin
            AVS_READDATA <= {24'h000000, rd_next};
        end
    end

    sequence s_rd_first(logic [5:0] i);
        AVS_READ && state_reg == IOSC_IDLE && idx == i;
    endsequence

    sequence s_rd_done;
        ##1 (AVS_READ && !AVS_WAITREQUEST);
    endsequence

    AST_BUS_ONE_WAIT: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        ((AVS_READ || AVS_WRITE) && state_reg == IOSC_IDLE) |=> !AVS_WAITREQUEST)
        else $error("bus access not answered after one wait cycle");

    AST_ID: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_rd_first(`IOSC_IDX_FAULT) ##0 s_rd_done |-> AVS_READDATA[4:0] == IDENTITY)
        else $error("identity field wrong");

    AST_FAULT: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_rd_first(`IOSC_IDX_FAULT) |=> AVS_READDATA[7:5] == {$past(gnd_s), |$past(vbl_s), !$past(extrst_s)})
        else $error("fault flags wrong");

    AST_EVENT_ADC: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_rd_first(`IOSC_IDX_EVENT) |=> AVS_READDATA[`IOSC_EVT_ADC_BIT] == $past(adc_s))
        else $error("conversion flag wrong");

    AST_EVENT_LSL: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_rd_first(`IOSC_IDX_EVENT) |=> AVS_READDATA[`IOSC_EVT_LSL_BIT] == $past(lsl_s))
        else $error("logic supply flag wrong");

    AST_FORCE_OFF: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !force_s |=> IO_DRIVE_EN == 16'h0000)
        else $error("output driven while forced off");

    AST_OE_GATE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        ##1 (IO_DRIVE_EN & ~$past(oe_reg)) == 16'h0000)
        else $error("output driven without its enable");

    AST_DIR_GATE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        ##1 (IO_DRIVE_EN & ~$past(dir16)) == 16'h0000)
        else $error("input group driven");

    AST_FLASH_PHASE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        ##1 (IO_DRIVE_EN & $past(flash_reg) & ~$past(phase16)) == 16'h0000)
        else $error("flashing output out of group phase");

    AST_HOT_OE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        over_s |=> oe_reg == 16'h0000 ##1 IO_DRIVE_EN == 16'h0000)
        else $error("overtemperature left outputs on");

    AST_HOT_FLASH: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        over_s |=> flash_reg == 16'h0000)
        else $error("overtemperature left flash on");

    AST_HOT_BIAS: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        over_s |=> thermal_off_reg ##1 BIAS == '0)
        else $error("bias on while hot");

    AST_EXT_RESET: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !extrst_s |=> oe_reg == 16'h0000 && dir_cfg_reg == 16'h0000 && clk_reg == `IOSC_RST_CLK)
        else $error("external reset did not load defaults");

endmodule : iosc_top
